// >>> pmtb_defines.svh
// Register offsets, field positions and reset values of the master time base
`ifndef PMTB_DEFINES_SVH
`define PMTB_DEFINES_SVH
`define PMTB_OFF_CTRL 12'h000
`define PMTB_OFF_CDIV 12'h004
`define PMTB_OFF_PER 12'h008
`define PMTB_OFF_SEC 12'h00c
`define PMTB_OFF_CHOP 12'h010
`define PMTB_OFF_STAT 12'h014
`define PMTB_CTRL_EN 15
`define PMTB_CTRL_SIDL 13
`define PMTB_CTRL_PEND 12
`define PMTB_CTRL_IEN 11
`define PMTB_CTRL_IPU 10
`define PMTB_CTRL_POL 9
`define PMTB_CTRL_OEN 8
`define PMTB_CTRL_XEN 7
`define PMTB_CTRL_WMASK 16'hafff
`define PMTB_CDIV_WMASK 16'h0007
`define PMTB_CHOP_WMASK 16'h83ff
`define PMTB_PER_RESET 16'hfff8
`define PMTB_SRC_PIN 3'h0
`define PMTB_SRC_TG16 3'h2
`define PMTB_SRC_TG17 3'h3
`define PMTB_DIV_MAX 3'h6
`endif

// >>> pmtb_pkg.sv
// Types of the master time base
package pmtb_pkg;
   typedef struct packed {
      logic en;
      logic sidl;
      logic pend;
      logic ien;
      logic ipu;
      logic pol;
      logic oen;
      logic xen;
      logic [2:0] src;
      logic [3:0] ps;
   } pmtb_ctrl_s;
   typedef struct packed {
      pmtb_ctrl_s ctrl;
      logic [2:0] cdiv;
      logic [15:0] per;
      logic [15:0] per_act;
      logic per_new;
      logic [15:0] sec;
      logic chen;
      logic [9:0] chdiv;
      logic [5:0] pre_cnt;
      logic [15:0] tmr;
      logic [3:0] ps_cnt;
      logic [9:0] ch_cnt;
      logic chop;
      logic trig;
      logic sync_o;
      logic [1:0] pin_s1;
      logic [1:0] pin_s2;
      logic sync_prev;
      logic [31:0] rdata;
   } pmtb_state_s;
endpackage : pmtb_pkg

// >>> pmtb_sync_model.sv
// Far-side model of the sync pin and trigger generator outputs
`timescale 1ns/100ps
module pmtb_sync_model (
   // Clock
   input wire logic clk_i,
   // Sync sources
   output logic sync_pin_o,
   output logic tg16_o,
   output logic tg17_o
);
   logic act_low;
   initial begin
      act_low = 1'b0;
      sync_pin_o = 1'b0;
      tg16_o = 1'b0;
      tg17_o = 1'b0;
   end
   // Park the pin at its inactive level
   task automatic set_pol(input logic low);
      act_low = low;
      sync_pin_o <= low;
      @(posedge clk_i);
   endtask : set_pol
   // Four-cycle active pulse; code 3 drives every source
   task automatic pulse(input int which);
      sync_pin_o <= (which == 0 || which == 3) ? ~act_low : act_low;
      tg16_o <= (which == 1 || which == 3);
      tg17_o <= (which >= 2);
      repeat (4) @(posedge clk_i);
      sync_pin_o <= act_low;
      tg16_o <= 1'b0;
      tg17_o <= 1'b0;
      @(posedge clk_i);
   endtask : pulse
endmodule : pmtb_sync_model

// >>> pmtb_top.sv
// Primary master time base with APB register slave
`timescale 1ns/100ps
`include "pmtb_defines.svh"
module pmtb_top
   import pmtb_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // System
   input wire logic cpu_idle_i,
   // Sync sources and outputs
   input wire logic sync_input_pin_i,
   input wire logic trigger_gen_output_16_i,
   input wire logic trigger_gen_output_17_i,
   output logic sync_output_pin_o,
   output logic sync_output_pin_oe_o,
   // Time base to generators
   output logic [15:0] primary_time_base_counter_o,
   output logic [15:0] primary_period_o,
   output logic tick_o,
   output logic special_event_trigger_o,
   output logic special_event_irq_o,
   output logic chop_clk_o
);
   pmtb_state_s s_q;
   pmtb_state_s s_d;
   logic wr;
   logic rd;
   logic tick;
   logic run;
   logic sync_raw;
   logic sync_act;
   logic sync_edge;
   logic wrap;
   logic match;
   logic [5:0] div_max;
   logic [15:0] ctrl_rd;
   always_comb begin
      wr = psel_i & penable_i & pwrite_i;
      rd = psel_i & ~penable_i & ~pwrite_i;
      // Prescaler terminal count per code
      div_max = 6'((7'h01 << s_q.cdiv) - 7'h01);
      run = s_q.ctrl.en & ~(s_q.ctrl.sidl & cpu_idle_i);
      tick = run & (s_q.pre_cnt >= div_max);
      case (s_q.ctrl.src)
         `PMTB_SRC_PIN: sync_raw = s_q.pin_s2[1];
         `PMTB_SRC_TG16: sync_raw = s_q.pin_s2[0];
         `PMTB_SRC_TG17: sync_raw = trigger_gen_output_17_i;
         default: sync_raw = 1'b0;
      endcase
      sync_act = sync_raw ^ (s_q.ctrl.pol & (s_q.ctrl.src == `PMTB_SRC_PIN));
      sync_edge = s_q.ctrl.xen & sync_act & ~s_q.sync_prev;
      wrap = tick & (s_q.tmr >= s_q.per_act);
      match = tick & (s_q.tmr == s_q.sec);
      ctrl_rd = {s_q.ctrl.en, 1'b0, s_q.ctrl.sidl, s_q.ctrl.pend, s_q.ctrl.ien,
                 s_q.ctrl.ipu, s_q.ctrl.pol, s_q.ctrl.oen, s_q.ctrl.xen,
                 s_q.ctrl.src, s_q.ctrl.ps};
   end
   always_comb begin
      s_d = s_q;
      s_d.pin_s1 = {sync_input_pin_i, trigger_gen_output_16_i};
      s_d.pin_s2 = s_q.pin_s1;
      s_d.sync_prev = s_q.ctrl.xen & sync_act;
      s_d.trig = 1'b0;
      // Register writes
      if (wr) begin
         case (paddr_i)
            `PMTB_OFF_CTRL: begin
               s_d.ctrl.en = pwdata_i[`PMTB_CTRL_EN];
               s_d.ctrl.sidl = pwdata_i[`PMTB_CTRL_SIDL];
               s_d.ctrl.ien = pwdata_i[`PMTB_CTRL_IEN];
               s_d.ctrl.ipu = pwdata_i[`PMTB_CTRL_IPU];
               s_d.ctrl.pol = pwdata_i[`PMTB_CTRL_POL];
               s_d.ctrl.oen = pwdata_i[`PMTB_CTRL_OEN];
               s_d.ctrl.xen = pwdata_i[`PMTB_CTRL_XEN];
               s_d.ctrl.src = pwdata_i[6:4];
               s_d.ctrl.ps = pwdata_i[3:0];
            end
            `PMTB_OFF_CDIV: s_d.cdiv = (pwdata_i[2:0] > `PMTB_DIV_MAX) ?
                                       `PMTB_DIV_MAX : pwdata_i[2:0];
            `PMTB_OFF_PER: begin
               s_d.per = pwdata_i[15:0];
               s_d.per_new = 1'b1;
            end
            `PMTB_OFF_SEC: s_d.sec = pwdata_i[15:0];
            `PMTB_OFF_CHOP: begin
               s_d.chen = pwdata_i[15];
               s_d.chdiv = pwdata_i[9:0];
            end
            default: ;
         endcase
      end
      // Active period shadow
      if (s_d.per_new & (s_q.ctrl.ipu | ~s_q.ctrl.en | wrap | sync_edge)) begin
         s_d.per_act = s_d.per;
         s_d.per_new = 1'b0;
      end
      // Prescaler and counter
      if (!run) begin
         s_d.pre_cnt = 6'h00;
         if (!s_q.ctrl.en) begin
            s_d.tmr = 16'h0000;
            s_d.ps_cnt = 4'h0;
         end
      end else begin
         s_d.pre_cnt = tick ? 6'h00 : s_q.pre_cnt + 6'h01;
      end
      if (sync_edge & run) begin
         s_d.tmr = 16'h0000;
      end else if (wrap) begin
         s_d.tmr = 16'h0000;
      end else if (tick) begin
         s_d.tmr = s_q.tmr + 16'h0001;
      end
      s_d.sync_o = wrap | (sync_edge & run);
      // Postscaler
      if (match) begin
         if (s_q.ps_cnt >= s_q.ctrl.ps) begin
            s_d.ps_cnt = 4'h0;
            s_d.trig = 1'b1;
         end else begin
            s_d.ps_cnt = s_q.ps_cnt + 4'h1;
         end
      end
      // Pending bit: set wins, cleared by hardware when interrupt enable is dropped
      if (s_q.trig & s_q.ctrl.ien) begin
         s_d.ctrl.pend = 1'b1;
      end else if (!s_d.ctrl.ien) begin
         s_d.ctrl.pend = 1'b0;
      end
      // Chop generator
      if (!s_q.chen | !s_q.ctrl.en) begin
         s_d.ch_cnt = 10'h000;
         s_d.chop = 1'b0;
      end else if (tick) begin
         if (s_q.ch_cnt >= s_q.chdiv) begin
            s_d.ch_cnt = 10'h000;
            s_d.chop = ~s_q.chop;
         end else begin
            s_d.ch_cnt = s_q.ch_cnt + 10'h001;
         end
      end
      // Read data captured in setup phase
      if (rd) begin
         case (paddr_i)
            `PMTB_OFF_CTRL: s_d.rdata = {16'h0000, ctrl_rd};
            `PMTB_OFF_CDIV: s_d.rdata = {29'h0, s_q.cdiv};
            `PMTB_OFF_PER: s_d.rdata = {16'h0000, s_q.per};
            `PMTB_OFF_SEC: s_d.rdata = {16'h0000, s_q.sec};
            `PMTB_OFF_CHOP: s_d.rdata = {16'h0000, s_q.chen, 5'h00, s_q.chdiv};
            `PMTB_OFF_STAT: s_d.rdata = {16'h0000, s_q.tmr};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.per <= `PMTB_PER_RESET;
         s_q.per_act <= `PMTB_PER_RESET;
      end else begin
         s_q <= s_d;
      end
   end
   always_comb begin
      prdata_o = s_q.rdata;
      pready_o = 1'b1;
      pslverr_o = psel_i & penable_i & (paddr_i > `PMTB_OFF_STAT);
      primary_time_base_counter_o = s_q.tmr;
      primary_period_o = s_q.per_act;
      tick_o = tick;
      special_event_trigger_o = s_q.trig;
      special_event_irq_o = s_q.trig & s_q.ctrl.ien;
      chop_clk_o = s_q.chop;
      sync_output_pin_oe_o = s_q.ctrl.oen;
      sync_output_pin_o = s_q.ctrl.oen & (s_q.sync_o ^ s_q.ctrl.pol);
   end
   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence seq_match_s;
      match;
   endsequence
   off_holds_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !s_q.ctrl.en |=> s_q.tmr == 16'h0000) else $error("counter moved while off");
   idle_halt_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.sidl & cpu_idle_i) |-> !tick) else $error("tick during idle stop");
   irq_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      special_event_irq_o |-> s_q.ctrl.ien) else $error("irq while disabled");
   pend_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      special_event_irq_o |=> s_q.ctrl.pend) else $error("pending not set");
   oe_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !s_q.ctrl.oen |-> !sync_output_pin_o && !sync_output_pin_oe_o)
      else $error("sync out driven while disabled");
   wrap_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wrap |=> s_q.tmr == 16'h0000) else $error("no restart after period");
   trig_ratio_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (seq_match_s and s_q.ctrl.ps == 4'h0) |=> special_event_trigger_o)
      else $error("1:1 trigger missing");
   ipu_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wr && paddr_i == `PMTB_OFF_PER && s_q.ctrl.ipu) |=> s_q.per_act == $past(pwdata_i[15:0]))
      else $error("immediate period not loaded");
   chop_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !s_q.chen |=> !chop_clk_o) else $error("chop runs while disabled");

   // ------------------------------------------------------------------
   // Enable, idle and prescaler checks
   // ------------------------------------------------------------------
   run_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !s_q.ctrl.en |-> !tick) else $error("tick while disabled");
   chop_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !s_q.ctrl.en |=> !chop_clk_o) else $error("chop clock while disabled");
   idle_freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.sidl && cpu_idle_i) |=> $stable(s_q.tmr))
      else $error("counter moved during idle stop");
   idle_run_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.en && !s_q.ctrl.sidl && s_q.pre_cnt >= div_max) |-> tick)
      else $error("tick lost while idle stop is off");
   div_clamp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_q.cdiv <= `PMTB_DIV_MAX) else $error("reserved prescale code held");
   tick_rate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (run && s_q.pre_cnt < div_max) |-> !tick)
      else $error("tick before prescaler terminal count");
   pre_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !run |=> s_q.pre_cnt == 6'h00)
      else $error("prescaler not cleared while stopped");

   // ------------------------------------------------------------------
   // Counter and sync checks
   // ------------------------------------------------------------------
   sequence seq_sync_take_s;
      sync_edge && run;
   endsequence
   sequence seq_plain_tick_s;
      tick && !wrap && !sync_edge;
   endsequence
   count_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      seq_plain_tick_s |=> s_q.tmr == $past(s_q.tmr) + 16'h0001)
      else $error("counter did not step on tick");
   count_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (run && !tick && !sync_edge) |=> $stable(s_q.tmr))
      else $error("counter moved without tick");
   sync_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      seq_sync_take_s |=> s_q.tmr == 16'h0000) else $error("no restart on sync");
   sync_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !s_q.ctrl.xen |-> !sync_edge) else $error("sync taken while disabled");
   reserved_src_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.src != `PMTB_SRC_PIN && s_q.ctrl.src != `PMTB_SRC_TG16 &&
       s_q.ctrl.src != `PMTB_SRC_TG17) |-> !sync_edge)
      else $error("sync from reserved source");
   tg17_route_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.xen && s_q.ctrl.src == `PMTB_SRC_TG17 && trigger_gen_output_17_i &&
       !s_q.sync_prev) |-> sync_edge)
      else $error("trigger 17 sync missed");
   tg16_route_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.xen && s_q.ctrl.src == `PMTB_SRC_TG16 && s_q.pin_s2[0] &&
       !s_q.sync_prev) |-> sync_edge)
      else $error("trigger 16 sync missed");
   pin_pol_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.xen && s_q.ctrl.src == `PMTB_SRC_PIN &&
       (s_q.pin_s2[1] != s_q.ctrl.pol) && !s_q.sync_prev) |-> sync_edge)
      else $error("pin sync missed at its polarity");
   sync_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wrap && s_q.ctrl.oen && !wr) |=>
      sync_output_pin_o == !s_q.ctrl.pol)
      else $error("sync out not active after wrap");
   sync_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!wrap && !(sync_edge && run) && s_q.ctrl.oen && !wr) |=> sync_output_pin_o == s_q.ctrl.pol)
      else $error("sync out active without event");

   // ------------------------------------------------------------------
   // Period update checks
   // ------------------------------------------------------------------
   sequence seq_per_write_s;
      wr && paddr_i == `PMTB_OFF_PER;
   endsequence
   boundary_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.en && !s_q.ctrl.ipu && !wrap && !sync_edge) |=>
      $stable(s_q.per_act))
      else $error("active period changed inside a cycle");
   boundary_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wrap && s_q.per_new && !wr) |=>
      s_q.per_act == $past(s_q.per))
      else $error("pending period not loaded at boundary");
   off_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!s_q.ctrl.en && s_q.per_new && !wr) |=>
      s_q.per_act == $past(s_q.per))
      else $error("period not loaded while off");
   ipu_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (seq_per_write_s ##0 s_q.ctrl.ipu) |=> !s_q.per_new)
      else $error("immediate period left pending");

   // ------------------------------------------------------------------
   // Special event checks
   // ------------------------------------------------------------------
   trig_source_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      special_event_trigger_o |-> $past(match))
      else $error("trigger without compare match");
   ps_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (match && s_q.ps_cnt < s_q.ctrl.ps) |=>
      !special_event_trigger_o && s_q.ps_cnt == $past(s_q.ps_cnt) + 4'h1)
      else $error("postscaler miscounted");
   ps_wrap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (match && s_q.ps_cnt >= s_q.ctrl.ps) |=> special_event_trigger_o && s_q.ps_cnt == 4'h0)
      else $error("postscaler terminal count missed");
   match_eq_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (tick && s_q.tmr == s_q.sec) |=> special_event_trigger_o || s_q.ps_cnt != 4'h0)
      else $error("compare match not counted");
   irq_forward_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (special_event_trigger_o && s_q.ctrl.ien) |-> special_event_irq_o)
      else $error("enabled request not forwarded");
   pend_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!s_q.ctrl.ien && !wr) |=> !s_q.ctrl.pend)
      else $error("pending kept while disabled");
   pend_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.ctrl.pend && s_q.ctrl.ien && !wr) |=> s_q.ctrl.pend)
      else $error("pending dropped while enabled");

   // ------------------------------------------------------------------
   // Chop and bus checks
   // ------------------------------------------------------------------
   chop_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.chen && s_q.ctrl.en && tick && s_q.ch_cnt >= s_q.chdiv) |=>
      chop_clk_o != $past(chop_clk_o))
      else $error("chop clock did not toggle");
   chop_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.chen && s_q.ctrl.en && !tick) |=> $stable(chop_clk_o))
      else $error("chop clock moved without tick");
   chop_cnt_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.chen && s_q.ctrl.en && tick && s_q.ch_cnt < s_q.chdiv) |=>
      s_q.ch_cnt == $past(s_q.ch_cnt) + 10'h001)
      else $error("chop divider miscounted");
   upper_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      prdata_o[31:16] == 16'h0000) else $error("upper read bits not zero");
   rdata_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
      else $error("read data changed outside setup");
   slverr_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (psel_i && penable_i && paddr_i <= `PMTB_OFF_STAT) |-> !pslverr_o)
      else $error("error on mapped address");
endmodule : pmtb_top

// >>> testbench.sv
// Self-checking bench of the primary master time base
`timescale 1ns/100ps
`include "pmtb_defines.svh"
module testbench;
   logic clk_i, rst, psel, pen, pwr, rdy, slv, err, idle, oe, trig, irq, chop, so, sp, g16, g17;
   logic tk;
   logic [11:0] pa;
   logic [31:0] pwd, prd, rd;
   logic [15:0] cnt, per;
   logic at_zero;
   int fail_count, tests_run, g;
   assign at_zero = (cnt == 16'h0);
   pmtb_top i_pmtb_top (.clk_i(clk_i), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
      .pslverr_o(slv), .cpu_idle_i(idle), .sync_input_pin_i(sp), .trigger_gen_output_16_i(g16),
      .trigger_gen_output_17_i(g17), .sync_output_pin_o(so), .sync_output_pin_oe_o(oe),
      .primary_time_base_counter_o(cnt), .primary_period_o(per), .tick_o(tk),
      .special_event_trigger_o(trig), .special_event_irq_o(irq), .chop_clk_o(chop));
   pmtb_sync_model i_pmtb_sync_model (.clk_i(clk_i), .sync_pin_o(sp), .tg16_o(g16),
      .tg17_o(g17));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic lost(input int n);
      if (n >= 3000) begin
         fail_count++;
         $display("ERROR %0t wait ran out", $time);
         give_verdict();
      end
   endtask : lost
   // Setup cycle, then access until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_i);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rdy !== 1'b1 && n < 3000);
      lost(n);
      rd = prd;
      err = slv;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rc
   // Cycles between two rising edges of s, left in g
   task automatic rise_gap(ref logic s);
      int n, r;
      logic p;
      p = 1'b1;
      n = 0;
      r = 0;
      g = 0;
      while (r < 2 && n < 3000) begin
         @(negedge clk_i);
         n++;
         if (r == 1) g++;
         if (s === 1'b1 && p !== 1'b1) r++;
         p = s;
      end
      lost(n);
      @(posedge clk_i);
   endtask : rise_gap
   task automatic ones(ref logic s, input int len);
      g = 0;
      repeat (len) begin
         @(negedge clk_i);
         if (s === 1'b1) g++;
      end
      @(posedge clk_i);
   endtask : ones
   task automatic wait_cnt(input logic [15:0] v);
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (cnt !== v && n < 3000);
      lost(n);
      @(posedge clk_i);
   endtask : wait_cnt
   task automatic t_regs();
      rc(`PMTB_OFF_PER, 32'h0000fff8);
      rc(`PMTB_OFF_CDIV, 32'h0);
      chk(per, 32'hfff8);
      wr(`PMTB_OFF_CTRL, 32'hffff7fff);
      rc(`PMTB_OFF_CTRL, 32'h00002fff);
      wr(`PMTB_OFF_CDIV, 32'hffffffff);
      rc(`PMTB_OFF_CDIV, 32'h6);
      wr(`PMTB_OFF_CHOP, 32'hffff7fff);
      rc(`PMTB_OFF_CHOP, 32'h3ff);
      apb(1'b0, 12'h018, 32'h0);
      chk(err, 32'h1);
      wr(`PMTB_OFF_CTRL, 32'h0);
      wr(`PMTB_OFF_CHOP, 32'h0);
      $display("regs done");
   endtask : t_regs
   task automatic t_div();
      wr(`PMTB_OFF_PER, 32'h3);
      for (int i = 0; i < 8; i++) begin
         wr(`PMTB_OFF_CDIV, i);
         wr(`PMTB_OFF_CTRL, 32'h8000);
         rise_gap(at_zero);
         chk(g, 4 << ((i > 6) ? 6 : i));
         wr(`PMTB_OFF_CTRL, 32'h0);
         repeat (20) @(posedge clk_i);
         chk(cnt, 32'h0);
      end
      wr(`PMTB_OFF_CDIV, 32'h0);
      $display("divider done");
   endtask : t_div
   task automatic t_idle();
      logic [15:0] c;
      wr(`PMTB_OFF_PER, 32'hc8);
      wr(`PMTB_OFF_CTRL, 32'ha000);
      idle <= 1'b1;
      repeat (3) @(posedge clk_i);
      c = cnt;
      repeat (10) @(posedge clk_i);
      chk(cnt, c);
      wr(`PMTB_OFF_CTRL, 32'h8000);
      c = cnt;
      repeat (10) @(posedge clk_i);
      chk(cnt, c + 16'ha);
      idle <= 1'b0;
      wr(`PMTB_OFF_CTRL, 32'h0);
      $display("idle done");
   endtask : t_idle
   task automatic t_event();
      int n;
      wr(`PMTB_OFF_PER, 32'h7);
      wr(`PMTB_OFF_SEC, 32'h3);
      for (int i = 0; i < 3; i++) begin
         n = (i == 2) ? 15 : i;
         wr(`PMTB_OFF_CTRL, 32'h8800 | n);
         rise_gap(trig);
         chk(g, 8 * (n + 1));
         rise_gap(irq);
         chk(g, 8 * (n + 1));
         rc(`PMTB_OFF_CTRL, 32'h9800 | n);
         wr(`PMTB_OFF_CTRL, 32'h8000 | n);
         rc(`PMTB_OFF_CTRL, 32'h8000 | n);
         ones(irq, 40);
         chk(g, 0);
         wr(`PMTB_OFF_CTRL, 32'h0);
      end
      $display("event done");
   endtask : t_event
   task automatic t_update();
      wr(`PMTB_OFF_PER, 32'h28);
      wr(`PMTB_OFF_CTRL, 32'h8400);
      wr(`PMTB_OFF_PER, 32'h14);
      chk(per, 32'h14);
      wr(`PMTB_OFF_CTRL, 32'h0);
      wr(`PMTB_OFF_CTRL, 32'h8000);
      wait_cnt(16'h5);
      wr(`PMTB_OFF_PER, 32'h1e);
      chk(per, 32'h14);
      wait_cnt(16'h0);
      chk(per, 32'h1e);
      wr(`PMTB_OFF_CTRL, 32'h0);
      $display("update done");
   endtask : t_update
   task automatic t_sout();
      wr(`PMTB_OFF_PER, 32'h7);
      wr(`PMTB_OFF_CTRL, 32'h8100);
      chk(oe, 32'h1);
      ones(so, 16);
      chk(g, 2);
      wr(`PMTB_OFF_CTRL, 32'h0);
      wr(`PMTB_OFF_CTRL, 32'h8300);
      ones(so, 16);
      chk(g, 14);
      wr(`PMTB_OFF_CTRL, 32'h0);
      wr(`PMTB_OFF_CTRL, 32'h8000);
      chk(oe, 32'h0);
      ones(so, 16);
      chk(g, 0);
      wr(`PMTB_OFF_CTRL, 32'h0);
      $display("sync out done");
   endtask : t_sout
   task automatic t_chop();
      wr(`PMTB_OFF_CDIV, 32'h2);
      wr(`PMTB_OFF_PER, 32'hc8);
      wr(`PMTB_OFF_CTRL, 32'h8000);
      ones(tk, 16);
      chk(g, 4);
      wr(`PMTB_OFF_CTRL, 32'h0);
      wr(`PMTB_OFF_CDIV, 32'h0);
      wr(`PMTB_OFF_CHOP, 32'h8003);
      wr(`PMTB_OFF_CTRL, 32'h8000);
      rise_gap(chop);
      chk(g, 8);
      wr(`PMTB_OFF_CHOP, 32'h3);
      ones(chop, 20);
      chk(g, 0);
      wr(`PMTB_OFF_CTRL, 32'h0);
      $display("chop done");
   endtask : t_chop
   task automatic sync_try(input int src, input logic pol, input logic xen);
      logic hit;
      hit = xen && (src == 0 || src == 2 || src == 3);
      i_pmtb_sync_model.set_pol(pol);
      wr(`PMTB_OFF_CTRL, 32'h8000 | (pol << 9) | (xen << 7) | (src << 4));
      wait_cnt(16'h3c);
      i_pmtb_sync_model.pulse((src == 0) ? 0 : (src == 2) ? 1 : (src == 3) ? 2 : 3);
      chk(cnt < 16'h28, hit);
      wr(`PMTB_OFF_CTRL, 32'h0);
   endtask : sync_try
   initial begin
      rst = 1'b1;
      {psel, pen, pwr, idle} = 4'h0;
      pa = 12'h0;
      pwd = 32'h0;
      fail_count = 0;
      tests_run = 0;
      repeat (2) @(posedge clk_i);
      rst <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_div();
      t_idle();
      t_event();
      t_update();
      t_sout();
      t_chop();
      wr(`PMTB_OFF_PER, 32'hc8);
      for (int s = 0; s < 8; s++) sync_try(s, 1'b0, 1'b1);
      sync_try(0, 1'b1, 1'b1);
      sync_try(2, 1'b0, 1'b0);
      $display("sync in done");
      give_verdict();
   end
endmodule : testbench
